// file: rtl/scfg_pkg.sv
package scfg_pkg;

    // ========================================================================
    // Register map
    localparam logic [1:0] REG_RESET_MUTE  = 2'h0;
    localparam logic [1:0] REG_DEEMPH_SEL  = 2'h1;  // deemphasis_select
    localparam logic [1:0] REG_IN_FMT_CH12 = 2'h2;  // input_format_ch12
    localparam logic [1:0] REG_IN_FMT_CH34 = 2'h3;  // input_format_ch34

    // ========================================================================
    // Reset values
    localparam logic [7:0] RST_RESET_MUTE  = 8'h01;
    localparam logic [7:0] RST_DEEMPH_SEL  = 8'h55;
    localparam logic [7:0] RST_IN_FMT      = 8'h00;

    // ========================================================================
    // Writable bit masks, other bits read as zero
    localparam logic [7:0] WMASK_RESET_MUTE = 8'hF5;
    localparam logic [7:0] WMASK_DEEMPH_SEL = 8'hFF;
    localparam logic [7:0] WMASK_IN_FMT     = 8'h77;

    // ========================================================================
    // Field positions
    localparam int POS_RESET_CTRL = 0;
    localparam int POS_BYPASS     = 2;
    localparam int POS_SMUTE      = 4;
    localparam int POS_FMT_LO     = 0;
    localparam int POS_FMT_HI     = 4;
    localparam int DEEMPH_W       = 2;
    localparam int FMT_W          = 3;
    localparam int NUM_CONV       = 4;

    // ========================================================================
    // Serial bus
    localparam logic [5:0] DEV_ADDR_FIXED = 6'h09;  // Upper six address bits 001001
    localparam logic [3:0] BITS_PER_BYTE  = 4'h8;

    // Per-converter configuration carrier
    typedef struct packed {
        logic [DEEMPH_W-1:0] deemph;
        logic [FMT_W-1:0]    fmt;
    } scfg_conv_t;

    // One-hot serial bus states
    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_DEV  = 8'h02,
        ST_REG  = 8'h04,
        ST_WR   = 8'h08,
        ST_ACK  = 8'h10,
        ST_RD   = 8'h20,
        ST_RACK = 8'h40,
        ST_SKIP = 8'h80
    } scfg_state_t;

endpackage

// file: rtl/scfg_reg_file.sv
`timescale 1ns/10ps
module scfg_reg_file
    import scfg_pkg::*;
(
    // Clock and reset
    input  wire logic            ref_clk,
    input  wire logic            rst,
    // Write port
    input  wire logic            wr_en,
    input  wire logic [1:0]      wr_addr,
    input  wire logic [7:0]      wr_data,
    // Read port
    input  wire logic [1:0]      rd_addr,
    output logic      [7:0]      rd_data,
    // Whole contents
    output logic [3:0][7:0]      regs
);

    // ========================================================================
    // Storage, read-only bits forced to zero on write
    function automatic logic [7:0] wmask(input logic [1:0] a);
        case (a)
            REG_RESET_MUTE: wmask = WMASK_RESET_MUTE;
            REG_DEEMPH_SEL: wmask = WMASK_DEEMPH_SEL;
            default:        wmask = WMASK_IN_FMT;
        endcase
    endfunction

    // Register array
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            regs[REG_RESET_MUTE]  <= RST_RESET_MUTE;
            regs[REG_DEEMPH_SEL]  <= RST_DEEMPH_SEL;
            regs[REG_IN_FMT_CH12] <= RST_IN_FMT;
            regs[REG_IN_FMT_CH34] <= RST_IN_FMT;
        end else if (wr_en) begin
            regs[wr_addr] <= wr_data & wmask(wr_addr);
        end
    end

    // Registered read data
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= regs[rd_addr];
        end
    end

endmodule // scfg_reg_file

// file: rtl/scfg_config.sv
// Notes on behaviour
// - Each converter has a 2-bit de-emphasis field, reset value 01 meaning off.
// - Serial mode ignores shared de-emphasis pins; each converter uses its field.
// - Each converter has a 3-bit input format field, reset value 000.
// - Serial mode ignores shared format pins; each converter uses its format field.
// - Format register 1: converter 2 in bits 6:4, converter 1 in 2:0.
// - Format register 2: converter 4 in bits 6:4, converter 3 in 2:0.
// - Address counter increments per byte and wraps from last register to first.
`timescale 1ns/10ps
module scfg_config
    import scfg_pkg::*;
(
    // Clock and reset (reset is the power-down input)
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    // Two-wire serial control bus
    input  wire logic                  scl_in,
    input  wire logic                  sda_in,
    output logic                       sda_out,
    output logic                       sda_drive_n,
    input  wire logic                  cad0,
    // Mode and shared pin settings
    input  wire logic                  serial_ctrl_select,
    input  wire logic [DEEMPH_W-1:0]   deemph_sel_pins,
    input  wire logic [FMT_W-1:0]      in_fmt_pins,
    // Effective settings
    output scfg_conv_t [NUM_CONV-1:0]  conv_cfg,
    output logic                       digital_reset_ctrl,
    output logic                       bypass_mode,
    output logic [NUM_CONV-1:0]        soft_mute
);

    // ========================================================================
    // Helpers
    function automatic logic [1:0] next_addr(input logic [1:0] a);
        next_addr = a + 2'h1;  // Natural wrap 3 -> 0
    endfunction

    // Declarations
    scfg_state_t  state;
    scfg_state_t  after_ack;
    logic         scl_q;
    logic         sda_q;
    logic [3:0]   bit_cnt;
    logic [7:0]   rx_shift;
    logic [7:0]   tx_shift;
    logic [1:0]   addr_ptr;
    logic         ack_drive;
    logic         master_nack;
    logic         wr_en;
    logic [7:0]   rd_data;
    logic [3:0][7:0] regs;
    logic         scl_rise;
    logic         scl_fall;
    logic         start_cond;
    logic         stop_cond;
    logic         byte_done;

    // ========================================================================
    // Bus line edges
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    // Start, stop and clock edge decode
    assign scl_rise   = scl_in & ~scl_q;
    assign scl_fall   = ~scl_in & scl_q;
    assign start_cond = scl_in & scl_q & sda_q & ~sda_in;
    assign stop_cond  = scl_in & scl_q & ~sda_q & sda_in;
    assign byte_done  = (bit_cnt == BITS_PER_BYTE);

    // Write strobe at the end of each data byte
    assign wr_en = scl_fall & byte_done & (state == ST_WR) & ~start_cond & ~stop_cond;

    // ========================================================================
    // Receive shifter and bit counter
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rx_shift <= 8'h00;
            bit_cnt  <= 4'h0;
        end else if (start_cond || stop_cond) begin
            bit_cnt <= 4'h0;
        end else if (scl_rise && (state == ST_DEV || state == ST_REG ||
                                  state == ST_WR || state == ST_RD)) begin
            rx_shift <= {rx_shift[6:0], sda_in};
            bit_cnt  <= bit_cnt + 4'h1;
        end else if (scl_fall && (state == ST_ACK || state == ST_RACK)) begin
            bit_cnt <= 4'h0;
        end
    end

    // Master acknowledge after a read byte
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            master_nack <= 1'b1;
        end else if (scl_rise && state == ST_RACK) begin
            master_nack <= sda_in;
        end
    end

    // ========================================================================
    // Transfer sequencer
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state     <= ST_IDLE;
            after_ack <= ST_IDLE;
            ack_drive <= 1'b0;
        end else if (start_cond) begin
            state     <= ST_DEV;
            ack_drive <= 1'b0;
        end else if (stop_cond) begin
            state     <= ST_IDLE;
            ack_drive <= 1'b0;
        end else if (scl_fall) begin
            case (state)
                ST_DEV: begin
                    if (byte_done) begin
                        if (rx_shift[7:1] == {DEV_ADDR_FIXED, cad0}) begin
                            state     <= ST_ACK;
                            ack_drive <= 1'b1;
                            after_ack <= rx_shift[0] ? ST_RD : ST_REG;
                        end else begin
                            state <= ST_SKIP;
                        end
                    end
                end
                ST_REG, ST_WR: begin
                    if (byte_done) begin
                        state     <= ST_ACK;
                        ack_drive <= 1'b1;
                        after_ack <= ST_WR;
                    end
                end
                ST_ACK: begin
                    state     <= after_ack;
                    ack_drive <= 1'b0;
                end
                ST_RD: begin
                    if (byte_done) begin
                        state <= ST_RACK;
                    end
                end
                ST_RACK: begin
                    state <= master_nack ? ST_SKIP : ST_RD;
                end
                ST_IDLE, ST_SKIP: begin
                    state <= state;
                end
                default: begin
                    state     <= ST_IDLE;
                    ack_drive <= 1'b0;
                end
            endcase
        end
    end

    // ========================================================================
    // Register address counter
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            addr_ptr <= REG_RESET_MUTE;
        end else if (scl_fall && !start_cond && !stop_cond) begin
            if (state == ST_REG && byte_done) begin
                addr_ptr <= rx_shift[1:0];  // Upper six bits are fixed zero
            end else if ((state == ST_WR || state == ST_RD) && byte_done) begin
                addr_ptr <= next_addr(addr_ptr);
            end
        end
    end

    // Transmit shifter, loaded when a read byte begins
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tx_shift <= 8'hFF;
        end else if (scl_fall && !start_cond && !stop_cond) begin
            if ((state == ST_ACK && after_ack == ST_RD) ||
                (state == ST_RACK && !master_nack)) begin
                tx_shift <= rd_data;
            end else if (state == ST_RD && !byte_done) begin
                tx_shift <= {tx_shift[6:0], 1'b1};
            end else if (state == ST_RD) begin
                tx_shift <= 8'hFF;
            end
        end
    end

    // Open-drain data line, enable low while pulling low
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sda_drive_n <= 1'b1;
        end else begin
            sda_drive_n <= ~(ack_drive | (state == ST_RD && !tx_shift[7]));
        end
    end
    assign sda_out = 1'b0;

    // ========================================================================
    // Register storage
    scfg_reg_file u_regs (
        .ref_clk (ref_clk),
        .rst     (rst),
        .wr_en   (wr_en),
        .wr_addr (addr_ptr),
        .wr_data (rx_shift),
        .rd_addr (addr_ptr),
        .rd_data (rd_data),
        .regs    (regs)
    );

    // ========================================================================
    // Effective per-converter settings, pin or register source
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_CONV; i++) begin
                conv_cfg[i].deemph <= RST_DEEMPH_SEL[DEEMPH_W-1:0];
                conv_cfg[i].fmt    <= RST_IN_FMT[FMT_W-1:0];
            end
        end else if (serial_ctrl_select) begin
            for (int i = 0; i < NUM_CONV; i++) begin
                conv_cfg[i].deemph <= regs[REG_DEEMPH_SEL][i*DEEMPH_W +: DEEMPH_W];
            end
            conv_cfg[0].fmt <= regs[REG_IN_FMT_CH12][POS_FMT_LO +: FMT_W];
            conv_cfg[1].fmt <= regs[REG_IN_FMT_CH12][POS_FMT_HI +: FMT_W];
            conv_cfg[2].fmt <= regs[REG_IN_FMT_CH34][POS_FMT_LO +: FMT_W];
            conv_cfg[3].fmt <= regs[REG_IN_FMT_CH34][POS_FMT_HI +: FMT_W];
        end else begin
            for (int i = 0; i < NUM_CONV; i++) begin
                conv_cfg[i].deemph <= deemph_sel_pins;
                conv_cfg[i].fmt    <= in_fmt_pins;
            end
        end
    end

    // Reset, bypass and mute controls
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            digital_reset_ctrl <= RST_RESET_MUTE[POS_RESET_CTRL];
            bypass_mode        <= RST_RESET_MUTE[POS_BYPASS];
            soft_mute          <= RST_RESET_MUTE[POS_SMUTE +: NUM_CONV];
        end else begin
            digital_reset_ctrl <= regs[REG_RESET_MUTE][POS_RESET_CTRL];
            bypass_mode        <= regs[REG_RESET_MUTE][POS_BYPASS];
            soft_mute          <= regs[REG_RESET_MUTE][POS_SMUTE +: NUM_CONV];
        end
    end

endmodule // scfg_config

// file: tb/scfg_config_chk.sv
`timescale 1ns/10ps
// ======
// Port checker
module scfg_config_chk
    import scfg_pkg::*;
(
    // Clock and reset
    input wire logic                 ref_clk,
    input wire logic                 rst,
    // Bus lines
    input wire logic                 scl_in,
    input wire logic                 sda_drive_n,
    // Mode and pins
    input wire logic                 serial_ctrl_select,
    input wire logic [DEEMPH_W-1:0]  deemph_sel_pins,
    input wire logic [FMT_W-1:0]     in_fmt_pins,
    // Effective settings
    input wire scfg_conv_t [NUM_CONV-1:0] conv_cfg
);
    // Fields of all converters side by side
    wire logic [7:0]  dm = {conv_cfg[3].deemph, conv_cfg[2].deemph,
                            conv_cfg[1].deemph, conv_cfg[0].deemph};
    wire logic [11:0] fm = {conv_cfg[3].fmt, conv_cfg[2].fmt, conv_cfg[1].fmt, conv_cfg[0].fmt};

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_dm_rst; $fell(rst) && serial_ctrl_select |-> (dm == 8'h55) [*2]; endproperty
    a_dm_rst: assert property (p_dm_rst)
        else $error("deemph not off after reset");
    property p_fm_rst; $fell(rst) && serial_ctrl_select |-> (fm == 12'h000) [*2]; endproperty
    a_fm_rst: assert property (p_fm_rst)
        else $error("format not mode 0 after reset");
    property p_dm_ign;
        serial_ctrl_select && $past(serial_ctrl_select) && $changed(deemph_sel_pins)
            |=> $stable(dm);
    endproperty
    a_dm_ign: assert property (p_dm_ign)
        else $error("deemph pins leak in serial mode");
    property p_fm_ign;
        serial_ctrl_select && $past(serial_ctrl_select) && $changed(in_fmt_pins) |=> $stable(fm);
    endproperty
    a_fm_ign: assert property (p_fm_ign)
        else $error("format pins leak in serial mode");
    property p_dm_par;
        !$past(serial_ctrl_select) && !$past(rst) |-> dm == {4{$past(deemph_sel_pins)}};
    endproperty
    a_dm_par: assert property (p_dm_par)
        else $error("deemph not from pins");
    property p_fm_par;
        !$past(serial_ctrl_select) && !$past(rst) |-> fm == {4{$past(in_fmt_pins)}};
    endproperty
    a_fm_par: assert property (p_fm_par)
        else $error("format not from pins");
    property p_sda_low; $changed(sda_drive_n) |-> !scl_in && !$past(scl_in); endproperty
    a_sda_low: assert property (p_sda_low)
        else $error("data line moved with clock high");
    property p_sda_hold; $fell(sda_drive_n) |-> !sda_drive_n [*6]; endproperty
    a_sda_hold: assert property (p_sda_hold)
        else $error("low bit too short");
endmodule // scfg_config_chk

bind scfg_config scfg_config_chk u_chk (.ref_clk(ref_clk), .rst(rst), .scl_in(scl_in),
    .sda_drive_n(sda_drive_n), .serial_ctrl_select(serial_ctrl_select),
    .deemph_sel_pins(deemph_sel_pins), .in_fmt_pins(in_fmt_pins), .conv_cfg(conv_cfg));

// file: tb/scfg_host.sv
`timescale 1ns/10ps
// ======
// Two-wire bus host model
module scfg_host (
    // Clock
    input  wire logic ref_clk,
    // Bus lines
    output logic      scl,
    output logic      sda,
    input  wire logic sda_line
);
    // Idle bus released high
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // Each phase lasts two falling edges
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // Start or repeated start
    task automatic start();
        sda = 1'b1;
        tick(2);
        scl = 1'b1;
        tick(2);
        sda = 1'b0;
        tick(2);
        scl = 1'b0;
        tick(2);
    endtask
    task automatic stop();
        sda = 1'b0;
        tick(2);
        scl = 1'b1;
        tick(2);
        sda = 1'b1;
        tick(2);
    endtask
    // Nine clocks, MSB first; line sampled mid high phase
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            sda = tx[i];
            tick(2);
            scl = 1'b1;
            tick(2);
            rx[i] = sda_line;
            tick(2);
            scl = 1'b0;
            tick(2);
        end
    endtask
endmodule // scfg_host

// file: tb/src_deemph_format_config_bench.sv
`timescale 1ns/10ps
// ======
// Configuration block bench
module src_deemph_format_config_bench
    import scfg_pkg::*;
;
    logic                      ref_clk = 1'b0;
    logic                      rst     = 1'b1;
    logic                      cad0    = 1'b0;
    logic                      serial_ctrl_select = 1'b1;
    logic [1:0]                deemph_sel_pins = 2'h0;
    logic [2:0]                in_fmt_pins     = 3'h0;
    logic                      scl, sda_host, sda_out, sda_drive_n, drc, byp;
    logic [3:0]                smute;
    scfg_conv_t [NUM_CONV-1:0] conv_cfg;
    logic [8:0]                rx;
    logic [7:0]                shadow [4];
    int                        errors = 0;
    int                        compares = 0;
    int                        cyc = 0;
    // Open-drain line with pull-up
    wire logic sda_line = sda_host & (sda_drive_n | sda_out);

    always #12.5 ref_clk = ~ref_clk;  // Jitter-free grid for every driven edge

    scfg_host host (.ref_clk(ref_clk), .scl(scl), .sda(sda_host), .sda_line(sda_line));
    scfg_config DUT (.ref_clk(ref_clk), .rst(rst), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_drive_n(sda_drive_n), .cad0(cad0),
        .serial_ctrl_select(serial_ctrl_select), .deemph_sel_pins(deemph_sel_pins),
        .in_fmt_pins(in_fmt_pins), .conv_cfg(conv_cfg), .digital_reset_ctrl(drc),
        .bypass_mode(byp), .soft_mute(smute));

    task automatic conclude();
        if (errors == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Expected settings from mode, pins and register shadow
    function automatic logic [19:0] exp_cfg();
        logic [19:0] e;
        for (int i = 0; i < 4; i++) begin
            e[5*i +: 5] = serial_ctrl_select ?
                {shadow[1][2*i +: 2], shadow[2+i/2][4*(i%2) +: 3]} : {deemph_sel_pins, in_fmt_pins};
        end
        return e;
    endfunction
    task automatic chk_cfg();
        repeat (2) @(negedge ref_clk);
        compares++;
        if (conv_cfg !== exp_cfg()) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, conv_cfg, exp_cfg());
        end
    endtask
    // Burst write; read-only bits kept zero in the shadow
    task automatic wr(input logic [7:0] ra, input logic [7:0] d [$]);
        logic [1:0] a;
        a = ra[1:0];
        host.start();
        host.xfer({DEV_ADDR_FIXED, cad0, 2'b01}, rx);
        chk_byte({7'h0, rx[0]}, 8'h00);
        host.xfer({ra, 1'b1}, rx);
        foreach (d[i]) begin
            host.xfer({d[i], 1'b1}, rx);
            shadow[a] = d[i] & (a == 0 ? 8'hF5 : a == 1 ? 8'hFF : 8'h77);
            a++;
        end
        host.stop();
    endtask
    // Random read of n bytes, host nacks the last
    task automatic rd(input logic [7:0] ra, input int n);
        logic [1:0] a;
        a = ra[1:0];
        host.start();
        host.xfer({DEV_ADDR_FIXED, cad0, 2'b01}, rx);
        host.xfer({ra, 1'b1}, rx);
        host.start();
        host.xfer({DEV_ADDR_FIXED, cad0, 2'b11}, rx);
        for (int i = 0; i < n; i++) begin
            host.xfer({8'hFF, i == n - 1}, rx);
            chk_byte(rx[8:1], shadow[a]);
            a++;
        end
        host.stop();
    endtask

    // Hang guard
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            conclude();
        end
    end

    // Main sequence
    initial begin
        shadow = '{8'h01, 8'h55, 8'h00, 8'h00};
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        chk_cfg();
        rd(8'h01, 3);
        deemph_sel_pins = 2'h2;
        in_fmt_pins = 3'h5;
        chk_cfg();
        wr(8'h00, '{8'h00, 8'h1B, 8'hFF, 8'hA5, 8'hFE});
        chk_byte({7'h0, drc}, 8'h00);
        chk_byte({3'h0, byp, smute}, {3'h0, shadow[0][2], shadow[0][7:4]});
        chk_cfg();
        rd(8'h02, 3);
        serial_ctrl_select = 1'b0;
        chk_cfg();
        deemph_sel_pins = 2'h1;
        in_fmt_pins = 3'h3;
        chk_cfg();
        serial_ctrl_select = 1'b1;
        chk_cfg();
        host.start();
        host.xfer({DEV_ADDR_FIXED, ~cad0, 2'b01}, rx);
        chk_byte({7'h0, rx[0]}, 8'h01);
        host.stop();
        rst = 1'b1;
        @(negedge ref_clk);
        rst = 1'b0;
        shadow = '{8'h01, 8'h55, 8'h00, 8'h00};
        chk_cfg();
        rd(8'h00, 4);
        // Current address read, counter wrapped back to the first register
        host.start();
        host.xfer({DEV_ADDR_FIXED, cad0, 2'b11}, rx);
        host.xfer(9'h1FF, rx);
        chk_byte(rx[8:1], shadow[0]);
        host.stop();
        conclude();
    end
endmodule // src_deemph_format_config_bench
